// [sim/can_acceptance_filter_regs_assertions.sv]
/* Port-level properties of the acceptance filter register block.
   Assumes: bound onto can_acceptance_filter_regs, one clock domain. */
`timescale 1ns/1ps
`default_nettype none

module can_acceptance_filter_regs_assertions (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        rst,
    // Register port
    input wire logic        sfr_wr,
    input wire logic        sfr_rd,
    input wire logic [7:0]  sfr_addr,
    input wire logic [7:0]  sfr_rdata,
    input wire logic        sfr_rvalid,
    // Object settings
    input wire logic        ext_format,
    input wire logic        auto_inc,
    input wire logic        ptr_load,
    input wire logic [2:0]  ptr_value,
    input wire logic [23:0] tag_high_bytes,
    // Frame side
    input wire logic        rx_valid,
    input wire logic        rx_hit_valid,
    input wire logic [28:0] tx_ident,
    input wire logic [2:0]  msg_ptr
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // Tag is undefined out of reset, so let the transmit copy settle
    logic [1:0] age_r;
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            age_r <= 2'h0;
        else if (age_r != 2'h3)
            age_r <= age_r + 2'h1;
    end

    sequence s_win;
        (sfr_rd || sfr_wr) && sfr_addr == can_filter_pkg::OFS_MESSAGE_DATA_WINDOW;
    endsequence
    sequence s_tag_quiet;
        !(sfr_wr && sfr_addr == can_filter_pkg::OFS_IDENT_TAG_BYTE4)
            && $stable(tag_high_bytes) && $stable(ext_format);
    endsequence

    property p_rd_resp;
        sfr_rd |=> sfr_rvalid;
    endproperty
    property p_rd_hold;
        !sfr_rd |=> $stable(sfr_rdata) && !sfr_rvalid;
    endproperty
    property p_hit_resp;
        rx_valid |=> rx_hit_valid;
    endproperty
    property p_hit_once;
        !rx_valid |=> !rx_hit_valid;
    endproperty
    property p_ptr_step;
        s_win ##0 (auto_inc && !ptr_load) |=> msg_ptr == $past(msg_ptr) + 3'h1;
    endproperty
    property p_ptr_load;
        ptr_load |=> msg_ptr == $past(ptr_value);
    endproperty
    property p_ptr_hold;
        !ptr_load && !(auto_inc && (sfr_rd || sfr_wr)
            && sfr_addr == can_filter_pkg::OFS_MESSAGE_DATA_WINDOW) |=> $stable(msg_ptr);
    endproperty
    property p_tx_hold;
        (age_r == 2'h3) ##0 s_tag_quiet ##1 s_tag_quiet |=> $stable(tx_ident);
    endproperty
    property p_std_m3;
        sfr_rd && !ext_format && sfr_addr == can_filter_pkg::OFS_IDENT_MASK_BYTE3
            |=> sfr_rdata == 8'h00;
    endproperty
    property p_m4_resv;
        sfr_rd && sfr_addr == can_filter_pkg::OFS_IDENT_MASK_BYTE4 |=> !sfr_rdata[1];
    endproperty

    a_rd_resp: assert property (p_rd_resp) else $error("read not answered");
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    a_hit_resp: assert property (p_hit_resp) else $error("frame not judged");
    a_hit_once: assert property (p_hit_once) else $error("stray verdict");
    a_ptr_step: assert property (p_ptr_step) else $error("pointer not stepped");
    a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded");
    a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved");
    a_tx_hold: assert property (p_tx_hold) else $error("tx ident moved");
    a_std_m3: assert property (p_std_m3) else $error("mask byte 3 not blank");
    a_m4_resv: assert property (p_m4_resv) else $error("mask bit 1 set");
endmodule

bind can_acceptance_filter_regs can_acceptance_filter_regs_assertions u_chk (
    .clk_sys(clk_sys), .rst(rst), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr),
    .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid), .ext_format(ext_format),
    .auto_inc(auto_inc), .ptr_load(ptr_load), .ptr_value(ptr_value),
    .tag_high_bytes(tag_high_bytes), .rx_valid(rx_valid), .rx_hit_valid(rx_hit_valid),
    .tx_ident(tx_ident), .msg_ptr(msg_ptr)
);
`default_nettype wire

// [sim/can_acceptance_filter_regs_tb.sv]
/* Self-checking bench: register view, acceptance filter and mailbox.
   Assumes: package, fifo, compare and top design files compiled first. */
`timescale 1ns/1ps
`default_nettype none

module can_acceptance_filter_regs_tb;
    logic        clk_sys, rst, sfr_wr, sfr_rd, ext_format, auto_inc, ptr_load;
    logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, rx_byte, d;
    logic [2:0]  ptr_value, msg_ptr;
    logic [23:0] tag_high_bytes;
    logic [28:0] rx_ident, tx_ident, id;
    logic        sfr_rvalid, rx_valid, rx_rtr, rx_ide, rx_hit, rx_hit_valid;
    logic        rx_byte_valid, rx_byte_ready, tx_rtr, rtr, ide;
    int          mismatches, total_checks;
    logic [7:0]  mr [4];
    logic [7:0]  t4;
    logic [7:0]  mbox [8];
    logic [7:0]  fq [$];
    logic [7:0]  adr [5];
    logic [7:0]  keep [2][5];

    can_acceptance_filter_regs dut (
        .clk_sys(clk_sys), .rst(rst), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid),
        .ext_format(ext_format), .auto_inc(auto_inc), .ptr_load(ptr_load),
        .ptr_value(ptr_value), .tag_high_bytes(tag_high_bytes), .rx_valid(rx_valid),
        .rx_ident(rx_ident), .rx_rtr(rx_rtr), .rx_ide(rx_ide), .rx_hit(rx_hit),
        .rx_hit_valid(rx_hit_valid), .rx_byte_valid(rx_byte_valid),
        .rx_byte_ready(rx_byte_ready), .rx_byte(rx_byte), .tx_ident(tx_ident),
        .tx_rtr(tx_rtr), .msg_ptr(msg_ptr)
    );
    can_engine_model eng (
        .clk_sys(clk_sys), .rx_valid(rx_valid), .rx_ident(rx_ident), .rx_rtr(rx_rtr),
        .rx_ide(rx_ide), .rx_byte_valid(rx_byte_valid), .rx_byte_ready(rx_byte_ready),
        .rx_byte(rx_byte)
    );

    always #5 clk_sys = ~clk_sys;

    // ------------------------------------------------------------
    // Reference model
    // ------------------------------------------------------------
    function automatic logic [28:0] tag_vec;
        return ext_format ? {tag_high_bytes, t4[7:3]} : {18'h0, tag_high_bytes[23:13]};
    endfunction
    function automatic logic exp_hit(input logic [28:0] i, input logic r, input logic e);
        logic [28:0] mk;
        mk = ext_format ? {mr[0], mr[1], mr[2], mr[3][7:3]} : {18'h0, mr[0], mr[1][7:5]};
        return (((i ^ tag_vec()) & mk) == 29'h0) && (!mr[3][2] || r == t4[2])
            && (!mr[3][0] || e == ext_format);
    endfunction

    task automatic chk(input logic [28:0] got, input logic [28:0] exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk_sys);
        sfr_wr = 1'b1;
        sfr_addr = a;
        sfr_wdata = v;
        @(negedge clk_sys);
        sfr_wr = 1'b0;
        sfr_wdata = ~v;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_sys);
        sfr_rd = 1'b1;
        sfr_addr = a;
        @(negedge clk_sys);
        sfr_rd = 1'b0;
        chk(sfr_rvalid, 1'b1, "rvalid");
        chk(sfr_rdata, e, "rdata");
    endtask
    task automatic load_ptr(input logic [2:0] v);
        @(negedge clk_sys);
        ptr_load = 1'b1;
        ptr_value = v;
        @(negedge clk_sys);
        ptr_load = 1'b0;
        ptr_value = ~v;
        chk(msg_ptr, v, "ptr load");
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        #200000;
        mismatches++;
        conclude();
    end

    initial
    begin
        {clk_sys, sfr_wr, sfr_rd, ptr_load, auto_inc, ext_format} = 6'h00;
        {sfr_addr, sfr_wdata, ptr_value, tag_high_bytes} = 43'h0;
        rst = 1'b1;
        adr = '{8'hC4, 8'hC5, 8'hC6, 8'hC7, 8'hBF};
        keep = '{'{8'hFF, 8'hE0, 8'h00, 8'h05, 8'h05}, '{8'hFF, 8'hFF, 8'hFF, 8'hFD, 8'hFF}};
        void'($urandom(10859));
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        // ------------------------------------------------------------
        // Register layout and filtering in both formats
        // ------------------------------------------------------------
        for (int f = 0; f < 2; f++)
        begin
            ext_format = f[0];
            tag_high_bytes = 24'($urandom);
            // Reserved positions are written with zeros, except bit 1 of tag byte 4 in extended format
            for (int i = 0; i < 5; i++)
            begin
                d = 8'($urandom) & 8'($urandom) & keep[f][i];
                wr_reg(adr[i], d);
                if (i < 4)
                    mr[i] = d;
                else
                    t4 = d;
            end
            for (int i = 0; i < 5; i++)
                rd_chk(adr[i], i < 4 ? mr[i] : t4);
            wr_reg(8'hC8, 8'h5A);
            rd_chk(8'hC8, 8'h00);
            for (int n = 0; n < 40; n++)
            begin
                id = tag_vec() ^ (29'($urandom) & 29'($urandom) & 29'($urandom));
                {rtr, ide} = 2'($urandom);
                eng.send_frame(id, rtr, ide);
                chk(rx_hit_valid, 1'b1, "verdict");
                chk(rx_hit, exp_hit(id, rtr, ide), "hit");
            end
            chk(ext_format ? tx_ident : {18'h0, tx_ident[10:0]}, tag_vec(), "tx id");
            chk(tx_rtr, t4[2], "tx rtr");
            $display("filter test done, format %0d", f);
        end
        // ------------------------------------------------------------
        // Buffer fill while window writes stall the pop, then drain
        // ------------------------------------------------------------
        load_ptr(3'h0);
        fork
            begin
                @(negedge clk_sys);
                sfr_wr = 1'b1;
                sfr_addr = can_filter_pkg::OFS_MESSAGE_DATA_WINDOW;
                repeat (16)
                begin
                    sfr_wdata = 8'($urandom);
                    @(negedge clk_sys);
                end
                chk(rx_byte_ready, 1'b0, "full");
                sfr_wr = 1'b0;
            end
            for (int i = 0; i < 9; i++)
            begin
                fq.push_back(8'($urandom));
                eng.push_byte(fq[i], i % 3 == 2);
            end
        join
        eng.idle_bytes();
        // Pops land one a cycle once the window is left alone
        repeat (12) @(negedge clk_sys);
        chk(rx_byte_ready, 1'b1, "drained");
        foreach (fq[i])
            mbox[i % 8] = fq[i];
        auto_inc = 1'b1;
        load_ptr(3'h0);
        for (int i = 0; i < 8; i++)
            rd_chk(can_filter_pkg::OFS_MESSAGE_DATA_WINDOW, mbox[i]);
        chk(msg_ptr, 3'h0, "wrap");
        load_ptr(3'h6);
        for (int i = 0; i < 3; i++)
        begin
            mbox[(6 + i) % 8] = 8'($urandom);
            wr_reg(can_filter_pkg::OFS_MESSAGE_DATA_WINDOW, mbox[(6 + i) % 8]);
        end
        load_ptr(3'h6);
        for (int i = 0; i < 3; i++)
            rd_chk(can_filter_pkg::OFS_MESSAGE_DATA_WINDOW, mbox[(6 + i) % 8]);
        chk(msg_ptr, 3'h1, "wrap write");
        $display("mailbox test done");
        conclude();
    end
endmodule
`default_nettype wire

// [sim/can_engine_model.sv]
/* Frame engine stand-in: offers received frames and data bytes.
   Assumes: driven by tasks from the bench, changes at falling edges. */
`timescale 1ns/1ps
`default_nettype none

module can_engine_model (
    // Clock
    input  wire logic        clk_sys,
    // Received frame
    output logic             rx_valid,
    output logic      [28:0] rx_ident,
    output logic             rx_rtr,
    output logic             rx_ide,
    // Received bytes
    output logic             rx_byte_valid,
    input  wire logic        rx_byte_ready,
    output logic      [7:0]  rx_byte
);
    initial
    begin
        rx_valid = 1'b0;
        rx_ident = 29'h0;
        rx_rtr = 1'b0;
        rx_ide = 1'b0;
        rx_byte_valid = 1'b0;
        rx_byte = 8'h00;
    end

    // Idle fields are inverted so stale values never look valid
    task automatic send_frame(input logic [28:0] id, input logic rtr, input logic ide);
        @(negedge clk_sys);
        rx_valid = 1'b1;
        rx_ident = id;
        rx_rtr = rtr;
        rx_ide = ide;
        @(negedge clk_sys);
        rx_valid = 1'b0;
        rx_ident = ~id;
        rx_rtr = ~rtr;
        rx_ide = ~ide;
    endtask

    // Held until ready is seen; ready is registered so it is sampled early
    task automatic push_byte(input logic [7:0] b, input bit gap);
        if (gap)
            idle_bytes();
        @(negedge clk_sys);
        rx_byte_valid = 1'b1;
        rx_byte = b;
        while (rx_byte_ready !== 1'b1)
            @(negedge clk_sys);
        @(posedge clk_sys);
    endtask

    task automatic idle_bytes;
        @(negedge clk_sys);
        rx_byte_valid = 1'b0;
        rx_byte = ~rx_byte;
    endtask
endmodule
`default_nettype wire

// [src/can_accept_match.sv]
/*
 * Combinational acceptance compare of a received frame against the
 * tag and mask fields of one message object.
 * Assumes: fields already unpacked from the register bytes.
 */
`timescale 1ns/1ps
`default_nettype none

module can_accept_match (
    // Object settings
    input  wire logic [28:0] tag_ident,
    input  wire logic [28:0] mask_ident,
    input  wire logic        tag_rtr,
    input  wire logic        mask_rtr,
    input  wire logic        tag_ide,
    input  wire logic        mask_ide,
    // Received frame
    input  wire logic [28:0] rx_ident,
    input  wire logic        rx_rtr,
    input  wire logic        rx_ide,
    // Result
    output logic             hit
);
    logic [30:0] differ;
    logic [30:0] enable;

    assign differ = {rx_ident ^ tag_ident, rx_rtr ^ tag_rtr, rx_ide ^ tag_ide};
    assign enable = {mask_ident, mask_rtr, mask_ide};
    assign hit = ((differ & enable) == '0);

endmodule

`default_nettype wire

// [src/can_acceptance_filter_regs.sv]
/*
 * Tag byte 4, mask bytes 1..4 and message data window of one CAN
 * message object, with its acceptance compare and mailbox.
 * Assumes: the CPU drives a one-cycle special function register
 * strobe with an 8-bit address; a frame engine offers received
 * frames and data bytes and takes transmit identifiers.
 */
`timescale 1ns/1ps
`default_nettype none


module can_acceptance_filter_regs (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // CPU register port
    input  wire logic        sfr_wr,
    input  wire logic        sfr_rd,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic [7:0]  sfr_wdata,
    output logic      [7:0]  sfr_rdata,
    output logic             sfr_rvalid,
    // Object configuration
    input  wire logic        ext_format,
    input  wire logic        auto_inc,
    input  wire logic        ptr_load,
    input  wire logic [2:0]  ptr_value,
    // Tag bytes 1..3 from the rest of the object
    input  wire logic [23:0] tag_high_bytes,
    // Received frame from the protocol engine
    input  wire logic        rx_valid,
    input  wire logic [28:0] rx_ident,
    input  wire logic        rx_rtr,
    input  wire logic        rx_ide,
    output logic             rx_hit,
    output logic             rx_hit_valid,
    // Received data bytes into the mailbox
    input  wire logic        rx_byte_valid,
    output logic             rx_byte_ready,
    input  wire logic [7:0]  rx_byte,
    // Transmit identifier and mailbox pointer
    output logic      [28:0] tx_ident,
    output logic             tx_rtr,
    output logic      [2:0]  msg_ptr
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    // No reset on tag or mask bytes: contents undefined after reset
    logic [7:0] ident_tag_byte4_r;
    logic [7:0] ident_mask_byte1_r;
    logic [7:0] ident_mask_byte2_r;
    logic [7:0] ident_mask_byte3_r;
    logic [7:0] ident_mask_byte4_r;
    logic [7:0] mailbox [can_filter_pkg::MAILBOX_DEPTH];
    logic [2:0] msg_ptr_r;
    logic [2:0] msg_ptr_nxt;
    logic [7:0] fill_ptr_r;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic hit_addr(input logic [7:0] a, input logic [7:0] ofs);
        hit_addr = (a == ofs);
    endfunction

    logic win_access;
    assign win_access = (sfr_wr || sfr_rd)
        && hit_addr(sfr_addr, can_filter_pkg::OFS_MESSAGE_DATA_WINDOW);

    // ------------------------------------------------------------
    // Tag and mask writes
    // ------------------------------------------------------------
    // reserved bits cleared on write, except bit 1 of tag byte 4 in extended format
    always_ff @(posedge clk_sys)
    begin
        if (sfr_wr)
        begin
            if (hit_addr(sfr_addr, can_filter_pkg::OFS_IDENT_TAG_BYTE4))
            begin
                // extended tag byte layout kept whole
                ident_tag_byte4_r <= ext_format ? sfr_wdata
                    : (sfr_wdata & 8'h05);
            end
            if (hit_addr(sfr_addr, can_filter_pkg::OFS_IDENT_MASK_BYTE1))
            begin
                ident_mask_byte1_r <= sfr_wdata;
            end
            if (hit_addr(sfr_addr, can_filter_pkg::OFS_IDENT_MASK_BYTE2))
            begin
                ident_mask_byte2_r <= ext_format ? sfr_wdata
                    : (sfr_wdata & 8'hE0);
            end
            if (hit_addr(sfr_addr, can_filter_pkg::OFS_IDENT_MASK_BYTE3))
            begin
                ident_mask_byte3_r <= ext_format ? sfr_wdata
                    : can_filter_pkg::RESERVED_FILL;
            end
            if (hit_addr(sfr_addr, can_filter_pkg::OFS_IDENT_MASK_BYTE4))
            begin
                ident_mask_byte4_r <= ext_format ? (sfr_wdata & 8'hFD)
                    : (sfr_wdata & 8'h05);
            end
        end
    end

    // ------------------------------------------------------------
    // Field unpacking
    // ------------------------------------------------------------
    logic [28:0] tag_ident;
    logic [28:0] mask_ident;
    logic        mask_rtr;
    logic        mask_ide;
    logic        tag_rtr;

    always_comb
    begin
        if (ext_format)
        begin
            // mask bits 28..5 across bytes 1..3
            tag_ident  = {tag_high_bytes,
                ident_tag_byte4_r[can_filter_pkg::BIT_LOW_IDENT_MSB:
                                  can_filter_pkg::BIT_LOW_IDENT_LSB]};
            mask_ident = {ident_mask_byte1_r, ident_mask_byte2_r, ident_mask_byte3_r,
                ident_mask_byte4_r[can_filter_pkg::BIT_LOW_IDENT_MSB:
                                   can_filter_pkg::BIT_LOW_IDENT_LSB]};
        end
        else
        begin
            tag_ident  = {18'h00000, tag_high_bytes[23:13]};
            mask_ident = {18'h00000, ident_mask_byte1_r,
                ident_mask_byte2_r[can_filter_pkg::STD_LOW_MSB:
                                   can_filter_pkg::STD_LOW_LSB]};
        end
        tag_rtr  = ident_tag_byte4_r[can_filter_pkg::BIT_REMOTE_REQ];
        mask_rtr = ident_mask_byte4_r[can_filter_pkg::BIT_REMOTE_REQ];
        mask_ide = ident_mask_byte4_r[can_filter_pkg::BIT_EXT_FLAG];
    end

    // ------------------------------------------------------------
    // Acceptance compare
    // ------------------------------------------------------------
    logic hit_comb;

    can_accept_match u_match (
        .tag_ident  (tag_ident),
        .mask_ident (mask_ident),
        .tag_rtr    (tag_rtr),
        .mask_rtr   (mask_rtr),
        .tag_ide    (ext_format),
        .mask_ide   (mask_ide),
        .rx_ident   (rx_ident),
        .rx_rtr     (rx_rtr),
        .rx_ide     (rx_ide),
        .hit        (hit_comb)
    );

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            rx_hit       <= 1'b0;
            rx_hit_valid <= 1'b0;
        end
        else
        begin
            rx_hit_valid <= rx_valid;
            rx_hit       <= rx_valid && hit_comb;
        end
    end

    // ------------------------------------------------------------
    // Transmit identifier
    // ------------------------------------------------------------
    // mask never touches transmit identifier
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            tx_ident <= 29'h00000000;
            tx_rtr   <= 1'b0;
        end
        else
        begin
            tx_ident <= tag_ident;
            tx_rtr   <= tag_rtr;
        end
    end

    // ------------------------------------------------------------
    // Receive byte FIFO into mailbox
    // ------------------------------------------------------------
    logic       fifo_valid;
    logic [7:0] fifo_data;
    logic       fifo_pop;

    can_fifo #(
        .WIDTH (can_filter_pkg::DATA_W),
        .DEPTH (can_filter_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .in_valid  (rx_byte_valid),
        .in_ready  (rx_byte_ready),
        .in_data   (rx_byte),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_data)
    );

    // CPU write to window has priority; FIFO stalls that cycle
    assign fifo_pop = fifo_valid
        && !(sfr_wr && hit_addr(sfr_addr, can_filter_pkg::OFS_MESSAGE_DATA_WINDOW));

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            fill_ptr_r <= 8'h00;
        end
        else if (fifo_pop)
        begin
            fill_ptr_r <= 8'((fill_ptr_r + 8'h01) & 8'h07);
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sfr_wr && hit_addr(sfr_addr, can_filter_pkg::OFS_MESSAGE_DATA_WINDOW))
        begin
            mailbox[msg_ptr_r] <= sfr_wdata;
        end
        else if (fifo_pop)
        begin
            mailbox[fill_ptr_r[2:0]] <= fifo_data;
        end
    end

    // ------------------------------------------------------------
    // Mailbox pointer
    // ------------------------------------------------------------
    always_comb
    begin
        msg_ptr_nxt = msg_ptr_r;
        if (ptr_load)
        begin
            msg_ptr_nxt = ptr_value;
        end
        else if (win_access && auto_inc)
        begin
            msg_ptr_nxt = (msg_ptr_r == can_filter_pkg::PTR_LAST)
                ? can_filter_pkg::PTR_FIRST : msg_ptr_r + 3'h1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            msg_ptr_r <= 3'h0;
            msg_ptr   <= 3'h0;
        end
        else
        begin
            msg_ptr_r <= msg_ptr_nxt;
            msg_ptr   <= msg_ptr_nxt;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            sfr_rdata  <= 8'h00;
            sfr_rvalid <= 1'b0;
        end
        else
        begin
            sfr_rvalid <= sfr_rd;
            if (sfr_rd)
            begin
                case (sfr_addr)
                    can_filter_pkg::OFS_MESSAGE_DATA_WINDOW: sfr_rdata <= mailbox[msg_ptr_r];
                    can_filter_pkg::OFS_IDENT_TAG_BYTE4:     sfr_rdata <= ident_tag_byte4_r;
                    can_filter_pkg::OFS_IDENT_MASK_BYTE1:    sfr_rdata <= ident_mask_byte1_r;
                    can_filter_pkg::OFS_IDENT_MASK_BYTE2:    sfr_rdata <= ident_mask_byte2_r;
                    can_filter_pkg::OFS_IDENT_MASK_BYTE3:    sfr_rdata <= ident_mask_byte3_r;
                    can_filter_pkg::OFS_IDENT_MASK_BYTE4:    sfr_rdata <= ident_mask_byte4_r;
                    default:
                        sfr_rdata <= can_filter_pkg::RESERVED_FILL;
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// [src/can_fifo.sv]
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes: one clock, asynchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none

module can_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             pop;

    assign out_valid = (count_r != '0);
    assign out_data  = mem[rd_ptr_r];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk_sys)
    begin
        if (push)
        begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
            in_ready <= 1'b1;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
            end
            if (push && !pop)
            begin
                count_r  <= count_r + 1'b1;
                in_ready <= (count_r != (AW+1)'(DEPTH-1));
            end
            else if (pop && !push)
            begin
                count_r  <= count_r - 1'b1;
                in_ready <= 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// [src/can_filter_pkg.sv]
/*
 * Register offsets, field positions and widths for the acceptance
 * filter register view and message data window.
 * Assumes: an 8-bit special function register bus with 8-bit addresses.
 */
package can_filter_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_MESSAGE_DATA_WINDOW = 8'hA3;
    localparam logic [7:0] OFS_IDENT_TAG_BYTE1     = 8'hBC;
    localparam logic [7:0] OFS_IDENT_TAG_BYTE2     = 8'hBD;
    localparam logic [7:0] OFS_IDENT_TAG_BYTE3     = 8'hBE;
    localparam logic [7:0] OFS_IDENT_TAG_BYTE4     = 8'hBF;
    localparam logic [7:0] OFS_IDENT_MASK_BYTE1    = 8'hC4;
    localparam logic [7:0] OFS_IDENT_MASK_BYTE2    = 8'hC5;
    localparam logic [7:0] OFS_IDENT_MASK_BYTE3    = 8'hC6;
    localparam logic [7:0] OFS_IDENT_MASK_BYTE4    = 8'hC7;

    // ------------------------------------------------------------
    // Field positions in byte 4
    // ------------------------------------------------------------
    localparam int BIT_REMOTE_REQ     = 2;
    localparam int BIT_RESERVED1      = 1;
    localparam int BIT_EXT_FLAG       = 0;
    localparam int BIT_LOW_IDENT_MSB  = 7;
    localparam int BIT_LOW_IDENT_LSB  = 3;

    // Standard format: mask bits 2..0 in bits 7..5 of byte 2
    localparam int STD_LOW_MSB        = 7;
    localparam int STD_LOW_LSB        = 5;

    // ------------------------------------------------------------
    // Sizes and fill value for reserved reads
    // ------------------------------------------------------------
    localparam int         MAILBOX_DEPTH   = 8;
    localparam int         PTR_W           = 3;
    localparam int         FIFO_DEPTH      = 8;
    localparam int         DATA_W          = 8;
    localparam logic [7:0] RESERVED_FILL   = 8'h00;
    localparam logic [2:0] PTR_LAST        = 3'h7;
    localparam logic [2:0] PTR_FIRST       = 3'h0;

endpackage
